// ===== rtl/btl_bus_modes.sv
`timescale 1ns/1ps
`default_nettype none
module btl_bus_modes
	import btl_pkg::*;
#(
	parameter int unsigned HOLDOFF = HOLDOFF_CYCLES,
	parameter int unsigned DISPLAY = DISPLAY_CYCLES,
	parameter int          TOK_MAX = 5
) (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	// Register port.
	input  wire logic [3:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	// Bus data received from the interface.
	input  wire logic [7:0] rxData,
	input  wire logic       rxValid,
	output logic            rxReady,
	// Bus data sent to the interface.
	output logic      [7:0] txData,
	output logic            txValid,
	input  wire logic       txReady,
	// Controller addressing and interface messages.
	input  wire logic       ctlTalkAddr,
	input  wire logic       ctlListenAddr,
	input  wire logic       ctlRemote,
	input  wire logic       devClearIn,
	input  wire logic       groupTrigIn,
	input  wire logic       serialPollIn,
	output logic            devClearOut,
	output logic            groupTrigOut,
	output logic            serialPollOut,
	output logic            ifaceReset,
	// Command interpreter side.
	output logic      [7:0] cmdData,
	output logic            cmdValid,
	input  wire logic [7:0] respData,
	input  wire logic       respValid,
	output logic            respReady,
	output logic            stepApply,
	output logic            stepDir,
	output logic      [2:0] stepFunc,
	// Front panel.
	input  wire logic       stepUpKey,
	input  wire logic       stepDownKey,
	input  wire logic [2:0] stepSel,
	input  wire logic       panelLangValid,
	input  wire logic [1:0] panelLang,
	output logic            addrLamp,
	output logic            localState,
	output logic            langShow,
	output logic      [1:0] langShown,
	// Non-volatile language storage.
	input  wire logic       nvLoadValid,
	input  wire logic [1:0] nvLoadLang,
	output logic            nvWrite,
	output logic      [1:0] nvLang
);
	initial begin
		if (TOK_MAX < 5 || TOK_MAX > 15) begin
			$error("btl_bus_modes needs TOK_MAX of five to fifteen characters");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode, language and error registers.

	logic [1:0]         mode;
	logic [1:0]         lang;
	logic               cmdErr;
	logic               cmdErrSet;
	logic               remoteLangSet;
	logic [1:0]         remoteLang;
	logic               localLangSet;
	logic [1:0]         localLang;
	logic               holdBusy;
	logic               showBusy;
	logic               txBusy;
	logic               talkOnly;
	logic               listenOnly;
	logic               listenActive;
	logic               talkActive;

	assign talkOnly     = (mode == MODE_TALK_ONLY);
	assign listenOnly   = (mode == MODE_LISTEN_ONLY);
	assign listenActive = listenOnly | ((mode == MODE_ADDRESSED) & ctlListenAddr);
	assign talkActive   = talkOnly | ((mode == MODE_ADDRESSED) & ctlTalkAddr);

	// A write of the same mode is not a change and leaves transfers alone.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			mode       <= MODE_RESET;
			ifaceReset <= 1'b0;
		end else begin
			ifaceReset <= 1'b0;
			if (regWr && regAddr == ADDR_MODE && regWdata[1:0] != mode
			    && regWdata[1:0] <= MODE_LISTEN_ONLY) begin
				mode       <= regWdata[1:0];
				ifaceReset <= 1'b1;
			end
		end
	end

	assign localLangSet = panelLangValid | (regWr && regAddr == ADDR_LANG);
	assign localLang    = panelLangValid ? panelLang : regWdata[1:0];

	// Later sources win within a cycle: remote command over local entry over reload.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lang <= LANG_RESET;
		end else if (remoteLangSet) begin
			lang <= remoteLang;
		end else if (localLangSet) begin
			lang <= localLang;
		end else if (nvLoadValid) begin
			lang <= nvLoadLang;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			nvWrite   <= 1'b0;
			nvLang    <= LANG_RESET;
			langShown <= LANG_RESET;
		end else begin
			nvWrite <= remoteLangSet | localLangSet;
			if (remoteLangSet) begin
				nvLang <= remoteLang;
			end else if (localLangSet) begin
				nvLang    <= localLang;
				langShown <= localLang;
			end
		end
	end

	// A fresh error in the cycle of a clear keeps the flag set.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmdErr <= 1'b0;
		end else if (cmdErrSet) begin
			cmdErr <= 1'b1;
		end else if (regWr && regAddr == ADDR_ERROR && regWdata[ERR_CMD]) begin
			cmdErr <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 8'h00;
		end else if (!regRd) begin
			regRdata <= 8'h00;
		end else if (regAddr == ADDR_MODE) begin
			regRdata <= {6'h00, mode};
		end else if (regAddr == ADDR_LANG) begin
			regRdata <= {6'h00, lang};
		end else if (regAddr == ADDR_STATUS) begin
			regRdata <= {3'h0, txBusy, showBusy, holdBusy, localState, addrLamp};
		end else if (regAddr == ADDR_ERROR) begin
			regRdata <= {7'h00, cmdErr};
		end else begin
			regRdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Timers for handshake reconfiguration and the language display.

	btl_tick_timer #(.CYCLES(HOLDOFF)) holdTimer (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.start   (remoteLangSet),
		.busy    (holdBusy)
	);

	btl_tick_timer #(.CYCLES(DISPLAY)) showTimer (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.start   (localLangSet),
		.busy    (showBusy)
	);

	assign langShow = showBusy;

	////////////////////////////////////////////////////////////////////////////////
	// Indicators and interface messages.

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			addrLamp      <= 1'b0;
			localState    <= 1'b1;
			devClearOut   <= 1'b0;
			groupTrigOut  <= 1'b0;
			serialPollOut <= 1'b0;
		end else begin
			addrLamp      <= talkActive | listenActive;
			localState    <= talkOnly | listenOnly | !ctlRemote;
			devClearOut   <= devClearIn & (mode == MODE_ADDRESSED);
			groupTrigOut  <= groupTrigIn & (mode == MODE_ADDRESSED);
			serialPollOut <= serialPollIn & (mode == MODE_ADDRESSED);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receive path and command token parser.

	logic                 rxTake;
	logic [8*TOK_MAX-1:0] tok;
	logic [3:0]           tokLen;
	logic                 commaLead;
	logic                 langArgWait;
	logic                 isSep;
	logic                 remStepSet;
	logic                 remStepDir;

	// Hold-off stalls the sender instead of dropping bytes mid reconfiguration.
	assign rxReady = listenActive & !holdBusy & !ifaceReset;
	assign rxTake  = rxValid & rxReady;
	assign isSep   = (rxData == CH_SEMI) | (rxData == CH_COMMA)
	               | (rxData == CH_LF) | (rxData == CH_SPACE);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmdData  <= 8'h00;
			cmdValid <= 1'b0;
		end else begin
			cmdValid <= rxTake & !ifaceReset;
			if (rxTake) begin
				cmdData <= rxData;
			end
		end
	end

	always_comb begin
		cmdErrSet     = 1'b0;
		remoteLangSet = 1'b0;
		remoteLang    = LANG_NATIVE;
		remStepSet    = 1'b0;
		remStepDir    = 1'b0;
		if (rxTake && isSep) begin
			if (langArgWait && tokLen != 4'h0) begin
				remoteLangSet = 1'b1;
				if (lang != LANG_NATIVE) begin
					remoteLang = LANG_NATIVE;
				end else if (tokLen == 4'h5 && tok[39:0] == TOK_NATIVE) begin
					remoteLang = LANG_NATIVE;
				end else if (tokLen == 4'h5 && tok[39:0] == TOK_LEGACY_A) begin
					remoteLang = LANG_LEGACY_A;
				end else if (tokLen == 4'h5 && tok[39:0] == TOK_LEGACY_B) begin
					remoteLang = LANG_LEGACY_B;
				end else if (tokLen == 4'h5 && tok[39:0] == TOK_LEGACY_C) begin
					remoteLang = LANG_LEGACY_C;
				end else begin
					remoteLangSet = 1'b0;
					cmdErrSet     = 1'b1;
				end
			end else if (langArgWait && rxData != CH_SPACE) begin
				remoteLangSet = 1'b1;
			end else if (!langArgWait && tokLen == 4'h3 && tok[23:0] == TOK_SELECT_LANG
			             && rxData != CH_SPACE) begin
				remoteLangSet = 1'b1;
			end else if (!langArgWait && tokLen == 4'h2
			             && (tok[15:0] == TOK_STEP_UP || tok[15:0] == TOK_STEP_DOWN)) begin
				if (commaLead && lang == LANG_NATIVE) begin
					cmdErrSet = 1'b1;
				end else begin
					remStepSet = 1'b1;
					remStepDir = (tok[15:0] == TOK_STEP_UP);
				end
			end
		end
	end

	// Compatibility languages parse the same tokens; common-command checks stay native only.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tok       <= '0;
			tokLen    <= 4'h0;
			commaLead <= 1'b0;
			langArgWait <= 1'b0;
		end else if (ifaceReset) begin
			tok       <= '0;
			tokLen    <= 4'h0;
			commaLead <= 1'b0;
			langArgWait <= 1'b0;
		end else if (rxTake) begin
			if (isSep) begin
				tok       <= '0;
				tokLen    <= 4'h0;
				commaLead <= (rxData == CH_COMMA);
				if (langArgWait) begin
					langArgWait <= (tokLen == 4'h0) && (rxData == CH_SPACE);
				end else begin
					langArgWait <= (tokLen == 4'h3) && (tok[23:0] == TOK_SELECT_LANG)
					           && (rxData == CH_SPACE);
				end
			end else if (tokLen < 4'(TOK_MAX)) begin
				tok    <= {tok[8*TOK_MAX-9:0], rxData};
				tokLen <= tokLen + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Step application and talk-only step broadcast.

	logic       keyStep;
	logic [1:0] txLeft;
	logic       txDown;

	assign keyStep = stepUpKey | stepDownKey;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stepApply <= 1'b0;
			stepDir   <= 1'b0;
			stepFunc  <= 3'h0;
		end else begin
			stepApply <= (keyStep | remStepSet) & (stepSel < STEP_FUNCS);
			stepDir   <= remStepSet ? remStepDir : stepUpKey;
			stepFunc  <= stepSel;
		end
	end

	// A key pressed while a string is still going out is applied locally but not sent.
	assign txBusy    = (txLeft != 2'h0);
	assign respReady = listenOnly | talkOnly | (talkActive & !txBusy & (!txValid | txReady));

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			txValid <= 1'b0;
			txData  <= 8'h00;
			txLeft  <= 2'h0;
			txDown  <= 1'b0;
		end else if (ifaceReset) begin
			txValid <= 1'b0;
			txLeft  <= 2'h0;
		end else if (!txValid || txReady) begin
			if (txLeft == 2'h3) begin
				txValid <= 1'b1;
				txData  <= TOK_STEP_UP[15:8];
				txLeft  <= 2'h2;
			end else if (txLeft == 2'h2) begin
				txValid <= 1'b1;
				txData  <= txDown ? TOK_STEP_DOWN[7:0] : TOK_STEP_UP[7:0];
				txLeft  <= 2'h1;
			end else if (txLeft == 2'h1) begin
				txValid <= 1'b0;
				txLeft  <= 2'h0;
			end else if (talkOnly && keyStep && (stepSel < STEP_FUNCS)) begin
				txValid <= 1'b1;
				txData  <= CH_SEMI;
				txDown  <= !stepUpKey;
				txLeft  <= 2'h3;
			end else if (mode == MODE_ADDRESSED && respValid && respReady) begin
				txValid <= 1'b1;
				txData  <= respData;
			end else begin
				txValid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ===== include/btl_pkg.sv
// Summary of operation
// - Listen-only accepts and acts on every bus data byte without being addressed.
// - Talk-only sends the step-up string per step-up key, step-down string per step-down key.
// - Step commands act on the locally selected one of six step functions.
// - Any change of talker/listener mode resets bus logic and drops transfers in flight.
// - Talk-only stays local, is always talk addressed, addressed lamp lit.
// - Listen-only stays local, is always listen addressed, addressed lamp lit.
// - Talk-only ignores device clear, group trigger and serial poll.
// - Listen-only ignores device clear, group trigger and serial poll.
// - Listen-only processes queries and calibration commands silently, sending nothing back.
// - Comma-prefixed step commands raise a command error under the native language.
// - Provide basic talk-only and listen-only interface functions.
// - Language code is 0 native, 1 to 3 for the three legacy languages.
// - A locally selected language is displayed for about two seconds.
// - The selected language is kept in non-volatile storage.
// - Language-select with no argument always switches to the native language.
// - In native language, language-select takes one of four language tokens.
// - Language switches interleaved with commands are honoured in order.
// - Compatibility languages need not follow the extended common-command standard.
package btl_pkg;
	localparam int unsigned CLK_HZ          = 50000000;
	localparam int unsigned HOLDOFF_MS      = 500;
	localparam int unsigned DISPLAY_MS      = 2000;
	localparam int unsigned HOLDOFF_CYCLES  = (CLK_HZ / 1000) * HOLDOFF_MS;
	localparam int unsigned DISPLAY_CYCLES  = (CLK_HZ / 1000) * DISPLAY_MS;

	localparam logic [3:0]  ADDR_MODE       = 4'h0;
	localparam logic [3:0]  ADDR_LANG       = 4'h4;
	localparam logic [3:0]  ADDR_STATUS     = 4'h8;
	localparam logic [3:0]  ADDR_ERROR      = 4'hc;

	localparam int          ST_ADDRESSED    = 0;
	localparam int          ST_LOCAL        = 1;
	localparam int          ST_HOLDOFF      = 2;
	localparam int          ST_DISPLAY      = 3;
	localparam int          ST_TXBUSY       = 4;
	localparam int          ERR_CMD         = 0;

	typedef enum logic [1:0] {MODE_ADDRESSED, MODE_TALK_ONLY, MODE_LISTEN_ONLY} btl_mode_t;
	typedef enum logic [1:0] {LANG_NATIVE, LANG_LEGACY_A, LANG_LEGACY_B, LANG_LEGACY_C} btl_lang_t;
	localparam logic [1:0]  MODE_RESET      = 2'h0;
	localparam logic [1:0]  LANG_RESET      = 2'h0;
	localparam logic [2:0]  STEP_FUNCS      = 3'h6;

	localparam logic [7:0]  CH_SEMI         = 8'h3b;
	localparam logic [7:0]  CH_COMMA        = 8'h2c;
	localparam logic [7:0]  CH_LF           = 8'h0a;
	localparam logic [7:0]  CH_SPACE        = 8'h20;
	localparam logic [15:0] TOK_STEP_UP     = 16'h5355;
	localparam logic [15:0] TOK_STEP_DOWN   = 16'h5344;
	localparam logic [23:0] TOK_SELECT_LANG = 24'h47414c;
	localparam logic [39:0] TOK_NATIVE      = 40'h4c36303830;
	localparam logic [39:0] TOK_LEGACY_A    = 40'h4c36303630;
	localparam logic [39:0] TOK_LEGACY_B    = 40'h4c36303730;
	localparam logic [39:0] TOK_LEGACY_C    = 40'h4c38363432;
endpackage

// ===== rtl/btl_tick_timer.sv
`timescale 1ns/1ps
`default_nettype none
module btl_tick_timer
	import btl_pkg::*;
#(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic start,
	output logic      busy
);
	localparam int W = $clog2(CYCLES + 1);
	logic [W-1:0] count;

	initial begin
		if (CYCLES < 1) begin
			$error("btl_tick_timer needs CYCLES of at least one");
		end
	end

	// A new start restarts the full period so the latest event sets the end time.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			count <= '0;
		end else if (start) begin
			count <= W'(CYCLES);
		end else if (count != '0) begin
			count <= count - W'(1);
		end
	end

	assign busy = (count != '0);
endmodule
`default_nettype wire

// ===== bench/btl_bus_modes_properties.sv
`timescale 1ns/1ps
`default_nettype none
module btl_bus_modes_properties
	import btl_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       resetn,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic [7:0] rxData,
	input wire logic       rxValid,
	input wire logic       rxReady,
	input wire logic [7:0] txData,
	input wire logic       txValid,
	input wire logic       txReady,
	input wire logic       devClearOut,
	input wire logic       groupTrigOut,
	input wire logic       serialPollOut,
	input wire logic       ifaceReset,
	input wire logic [7:0] cmdData,
	input wire logic       cmdValid,
	input wire logic       respReady,
	input wire logic       stepApply,
	input wire logic [2:0] stepFunc,
	input wire logic       addrLamp,
	input wire logic       localState,
	input wire logic       langShow,
	input wire logic       nvWrite,
	input wire logic [1:0] nvLang
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [1:0] curMode;
	// Shadow of the mode register, so the mode-dependent rules need no internal probe.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			curMode <= 2'h0;
		else if (regWr && regAddr == ADDR_MODE && regWdata[1:0] <= 2'h2)
			curMode <= regWdata[1:0];
	end
	sequence sSemiSent;
		txValid && txReady && txData == CH_SEMI && curMode == 2'h1 && !ifaceReset;
	endsequence
	sequence sLetterS;
		txValid && txData == TOK_STEP_UP[15:8];
	endsequence
	AST_TX_HOLD: assert property (txValid && !txReady && !ifaceReset |=> txValid && $stable(txData))
		else $error("tx byte not held");
	AST_TX_ORDER: assert property (sSemiSent |=> sLetterS)
		else $error("tx order wrong");
	AST_MODE_RESET: assert property (regWr && regAddr == ADDR_MODE && regWdata[1:0] <= 2'h2
		&& regWdata[1:0] != curMode |-> ##[1:2] ifaceReset) else $error("no iface reset");
	AST_TALK_LOCAL: assert property ((curMode == 2'h1)[*3] |-> addrLamp && localState)
		else $error("talk-only not local");
	AST_LISTEN_LOCAL: assert property ((curMode == 2'h2)[*3] |-> addrLamp && localState)
		else $error("listen-only not local");
	AST_TALK_MSGS: assert property ((curMode == 2'h1)[*2] |-> !devClearOut && !groupTrigOut
		&& !serialPollOut) else $error("talk-only passed message");
	AST_LISTEN_MSGS: assert property ((curMode == 2'h2)[*2] |-> !(devClearOut || groupTrigOut
		|| serialPollOut)) else $error("listen-only passed message");
	AST_RX_FORWARD: assert property (rxValid && rxReady |=> cmdValid && cmdData == $past(rxData))
		else $error("rx byte not forwarded");
	AST_LISTEN_SILENT: assert property ((curMode == 2'h2)[*3] |-> !txValid && respReady)
		else $error("listen-only sent data");
	AST_STEP_FUNC: assert property (stepApply |-> stepFunc < STEP_FUNCS)
		else $error("bad step function");
	AST_NV_WRITE: assert property (regWr && regAddr == ADDR_LANG |=> nvWrite
		&& nvLang == 2'($past(regWdata))) else $error("language not stored");
	AST_SHOW: assert property ($rose(langShow) |-> langShow [*8])
		else $error("language display too short");
endmodule
bind btl_bus_modes btl_bus_modes_properties chk (.sys_clk, .resetn, .regAddr, .regWdata, .regWr,
	.rxData, .rxValid, .rxReady, .txData, .txValid, .txReady, .devClearOut, .groupTrigOut,
	.serialPollOut, .ifaceReset, .cmdData, .cmdValid, .respReady, .stepApply, .stepFunc,
	.addrLamp, .localState, .langShow, .nvWrite, .nvLang);
`default_nettype wire

// ===== bench/btl_peer.sv
`timescale 1ns/1ps
`default_nettype none
module btl_peer (
	input  wire logic       sys_clk,
	input  wire logic       rxReady,
	input  wire logic [7:0] txData,
	input  wire logic       txValid,
	output logic      [7:0] rxData,
	output logic            rxValid,
	output logic            txReady
);
	logic [7:0] got[$];
	bit         slow;
	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
		txReady = 1'b0;
		slow = 1'b0;
	end
	// A slow listener stalls most cycles, so the talker must hold each byte.
	always @(posedge sys_clk) begin
		if (txValid && txReady)
			got.push_back(txData);
		txReady <= slow ? ($urandom % 4 == 0) : 1'b1;
	end
	// Sends the n low bytes of v, first byte highest.
	task automatic send(input logic [79:0] v, input int n);
		logic r;
		int   k;
		@(posedge sys_clk);
		for (int i = n - 1; i >= 0; i--) begin
			rxData <= v[8*i +: 8];
			rxValid <= 1'b1;
			k = 0;
			// Waiting out a refused byte is how the pause after a switch is kept.
			do begin
				@(negedge sys_clk);
				r = rxReady;
				@(posedge sys_clk);
				k++;
			end while (!r && k < 200);
		end
		rxValid <= 1'b0;
		rxData <= ~rxData;
		@(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
	import btl_pkg::*;
;
	`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
		$display("BAD %0t %h %h", $time, (a), (b)); end end
	logic       sys_clk = 1'b0, resetn = 1'b0, regWr = 1'b0, regRd = 1'b0, rxValid, rxReady;
	logic       txValid, txReady, devClearIn = 1'b0, groupTrigIn = 1'b0, serialPollIn = 1'b0;
	logic       devClearOut, groupTrigOut, serialPollOut, ifaceReset, cmdValid, respReady;
	logic       respValid = 1'b0, stepApply, stepDir, stepUpKey = 1'b0, stepDownKey = 1'b0;
	logic       panelLangValid = 1'b0, addrLamp, localState, langShow, nvLoadValid = 1'b0;
	logic       nvWrite, lastDir, d, ctlRemote = 1'b0;
	logic [1:0] panelLang = 2'h0, langShown, nvLoadLang = 2'h0, nvLang;
	logic [2:0] stepSel = 3'h0, stepFunc, lastFunc;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, regRdata, rxData, txData, cmdData, respData = 8'h00, v;
	logic [7:0] stepCnt = 8'h00, lastCmd = 8'h00;
	int         fail_count = 0, check_count = 0;
	btl_bus_modes #(.HOLDOFF(20), .DISPLAY(30)) uut (.sys_clk, .resetn, .regAddr, .regWdata,
		.regWr, .regRd, .regRdata, .rxData, .rxValid, .rxReady, .txData, .txValid, .txReady,
		.ctlTalkAddr(1'b0), .ctlListenAddr(1'b0), .ctlRemote, .devClearIn, .groupTrigIn,
		.serialPollIn, .devClearOut, .groupTrigOut, .serialPollOut, .ifaceReset, .cmdData,
		.cmdValid, .respData, .respValid, .respReady, .stepApply, .stepDir, .stepFunc,
		.stepUpKey, .stepDownKey, .stepSel, .panelLangValid, .panelLang, .addrLamp, .localState,
		.langShow, .langShown, .nvLoadValid, .nvLoadLang, .nvWrite, .nvLang);
	btl_peer peer (.sys_clk, .rxReady, .txData, .txValid, .rxData, .rxValid, .txReady);
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (stepApply === 1'b1) begin
			stepCnt <= stepCnt + 8'h01;
			lastDir <= stepDir;
			lastFunc <= stepFunc;
		end
		if (cmdValid === 1'b1)
			lastCmd <= cmdData;
	end
	//////////////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] dv);
		@(posedge sys_clk);
		regAddr <= a;
		regWdata <= dv;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] r);
		@(posedge sys_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 r = regRdata;
	endtask
	// Bus messages with a pending response; e is what the current mode lets through.
	task automatic msgs(input logic [2:0] e);
		@(posedge sys_clk);
		{devClearIn, groupTrigIn, serialPollIn, respValid} <= 4'hf;
		respData <= 8'($urandom);
		@(posedge sys_clk);
		{devClearIn, groupTrigIn, serialPollIn, respValid} <= 4'h0;
		@(posedge sys_clk);
		`CHK({devClearOut, groupTrigOut, serialPollOut}, e)
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge sys_clk);
		fail_count++;
		final_report();
	end
	initial begin
		void'($urandom(24793));
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(ADDR_STATUS, v); `CHK(v, 8'h02)
		rd(4'h2, v); `CHK(v, 8'h00)
		msgs(3'h7);
		wr(ADDR_MODE, 8'h02);
		ctlRemote <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(ADDR_STATUS, v); `CHK(v, 8'h03)
		msgs(3'h0);
		for (int i = 0; i < 8; i++) begin
			v = 8'h61 + 8'($urandom % 26);
			peer.send({v}, 1);
			@(posedge sys_clk);
			`CHK(lastCmd, v)
		end
		wr(ADDR_ERROR, 8'h01);
		for (int i = 0; i < 6; i++) begin
			d = 1'($urandom % 2);
			stepSel <= 3'(i);
			peer.send({CH_SEMI, d ? TOK_STEP_UP : TOK_STEP_DOWN, CH_SEMI}, 4);
			repeat (4) @(posedge sys_clk);
			`CHK(stepCnt, 8'(i + 1))
			`CHK(lastFunc, 3'(i))
			`CHK(lastDir, d)
		end
		stepSel <= 3'h7;
		peer.send({CH_SEMI, TOK_STEP_DOWN, CH_SEMI}, 4);
		repeat (4) @(posedge sys_clk);
		`CHK(stepCnt, 8'h06)
		stepSel <= 3'h2;
		peer.send({CH_COMMA, TOK_STEP_UP, CH_SEMI}, 4);
		repeat (3) @(posedge sys_clk);
		rd(ADDR_ERROR, v); `CHK(v, 8'h01)
		wr(ADDR_ERROR, 8'h01);
		peer.send({TOK_SELECT_LANG, CH_SPACE, TOK_LEGACY_A, CH_SEMI}, 10);
		peer.send({CH_COMMA, TOK_STEP_DOWN, CH_SEMI}, 4);
		repeat (4) @(posedge sys_clk);
		rd(ADDR_LANG, v); `CHK(v, 8'h01)
		rd(ADDR_ERROR, v); `CHK(v, 8'h00)
		`CHK(stepCnt, 8'h07)
		peer.send({TOK_SELECT_LANG, CH_SEMI}, 4);
		peer.send({CH_COMMA, TOK_STEP_UP, CH_SEMI}, 4);
		repeat (3) @(posedge sys_clk);
		rd(ADDR_LANG, v); `CHK(v, 8'h00)
		rd(ADDR_ERROR, v); `CHK(v, 8'h01)
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LANG, 8'(i));
			rd(ADDR_LANG, v); `CHK(v, 8'(i))
			`CHK(langShown, 2'(i))
			rd(ADDR_STATUS, v); `CHK(v[3], 1'b1)
		end
		@(posedge sys_clk) begin
			nvLoadValid <= 1'b1;
			nvLoadLang <= 2'h2;
		end
		@(posedge sys_clk) nvLoadValid <= 1'b0;
		rd(ADDR_LANG, v); `CHK(v, 8'h02)
		@(posedge sys_clk) begin
			panelLangValid <= 1'b1;
			panelLang <= 2'h0;
		end
		@(posedge sys_clk) panelLangValid <= 1'b0;
		rd(ADDR_LANG, v); `CHK(v, 8'h00)
		`CHK(peer.got.size(), 0)
		wr(ADDR_MODE, 8'h01);
		wr(ADDR_MODE, 8'h03);
		rd(ADDR_MODE, v); `CHK(v, 8'h01)
		peer.slow = 1'b1;
		msgs(3'h0);
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk) {stepUpKey, stepDownKey} <= i ? 2'h1 : 2'h2;
			@(posedge sys_clk) {stepUpKey, stepDownKey} <= 2'h0;
			for (int k = 0; k < 200 && peer.got.size() < 3; k++)
				@(posedge sys_clk);
			`CHK(peer.got.size(), 3)
			`CHK(peer.got[0], CH_SEMI)
			`CHK(peer.got[1], TOK_STEP_UP[15:8])
			`CHK(peer.got[2], i ? TOK_STEP_DOWN[7:0] : TOK_STEP_UP[7:0])
			peer.got.delete();
			repeat (4) @(posedge sys_clk);
		end
		rd(ADDR_STATUS, v); `CHK(v, 8'h03)
		final_report();
	end
endmodule
`default_nettype wire
